// ### bench/pad_ring_model.sv
`timescale 1ns/1ps
module pad_ring_model
    import pld_block_pkg::*;
(
    // Clock
    input  wire logic                mclk,
    // From the block
    input  wire logic [NUM_MC-1:0]   io_out,
    input  wire logic [NUM_MC-1:0]   io_oe,
    input  wire logic [NUM_MC-1:0]   io_pullup,
    // To the block
    output logic      [NUM_IN-1:0]   gia_out,
    output logic      [NUM_GPIN-1:0] gclk_pin,
    output logic                     uclk_pin,
    output logic                     gts_pin,
    output logic      [NUM_MC-1:0]   io_in
);
    logic [NUM_IN-1:0]   gia_q   = '0;
    logic [NUM_GPIN-1:0] gclk_q  = '0;
    logic                gts_q   = 1'b0;
    logic [NUM_MC-1:0]   ext_en  = '0;
    logic [NUM_MC-1:0]   ext_val = '0;
    logic [NUM_MC-1:0]   noise_q = '0;

    // Undriven pads wander so a stale level never passes as driven
    always_ff @(posedge mclk) begin
        noise_q <= ~noise_q;
    end

    assign gia_out  = gia_q;
    assign gclk_pin = gclk_q;
    assign uclk_pin = 1'b0;
    assign gts_pin  = gts_q;
    assign io_in    = (io_oe & io_out) | (~io_oe & ext_en & ext_val)
                    | (~io_oe & ~ext_en & io_pullup)
                    | (~io_oe & ~ext_en & ~io_pullup & noise_q);
endmodule

// ### bench/tb_pld_logic_block.sv
`timescale 1ns/1ps
module tb_pld_logic_block
    import pld_block_pkg::*;
    ;
    logic                mclk = 1'b0;
    logic                rst_n = 1'b0;
    logic [11:0]         address = '0;
    logic                bus_read = 1'b0;
    logic                bus_write = 1'b0;
    logic [31:0]         wdata = '0;
    logic [31:0]         rdata;
    logic                waitreq;
    logic [31:0]         got;
    logic                clk_en = 1'b1;
    logic [3:0]          be = 4'hf;
    logic [NUM_IN-1:0]   gia;
    logic [NUM_GPIN-1:0] gclk;
    logic                uclk;
    logic                gts;
    logic [NUM_MC-1:0]   mc_fb, pin_fb, io_in, io_out, io_oe, io_pu, io_slow;
    int                  n_errors = 0;
    int                  comparisons = 0;
    int                  cycles = 0;

    always #10 mclk = ~mclk;

    pld_logic_block u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
        .avs_address(address), .avs_read(bus_read), .avs_write(bus_write),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .global_interconnect_array_in(gia),
        .mc_feedback(mc_fb), .pin_feedback(pin_fb), .gclk_pin(gclk),
        .uclk_pin(uclk), .global_tristate_pin(gts), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .io_pullup(io_pu), .io_slow(io_slow));

    pad_ring_model u_pins (.mclk(mclk), .io_out(io_out), .io_oe(io_oe),
        .io_pullup(io_pu), .gia_out(gia), .gclk_pin(gclk), .uclk_pin(uclk),
        .gts_pin(gts), .io_in(io_in));

    task automatic chk(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        address   <= a;
        wdata     <= d;
        bus_write <= w;
        bus_read  <= !w;
        do @(posedge mclk); while (waitreq !== 1'b0);
        got = rdata;
        bus_write <= 1'b0;
        bus_read  <= 1'b0;
    endtask

    task automatic mc(input int m, input logic [31:0] w0, orm);
        bus(1, 12'h400 + 12'(m * 16), w0);
        bus(1, 12'h404 + 12'(m * 16), orm);
        bus(1, 12'h40c + 12'(m * 16), 32'h3f);
    endtask

    task automatic gia_set(input int b, input logic v);
        @(posedge mclk);
        u_pins.gia_q[b] <= v;
        cyc(6);
    endtask

    // Pin held several cycles so the sampled edge is never missed
    task automatic tick(input logic [3:0] pins);
        @(posedge mclk);
        u_pins.gclk_q <= pins;
        cyc(4);
        u_pins.gclk_q <= 4'h0;
        cyc(6);
    endtask

    task automatic t_bus;
        bus(0, 12'h800, 0);
        chk("ctrl reset", got, 32'h0);
        bus(1, 12'h08c, 32'h1);
        bus(0, 12'h08c, 0);
        chk("term word 3", got, 32'h0);
        bus(0, 12'h900, 0);
        chk("unmapped", got, 32'h0);
        bus(1, 12'h080, 32'h1);
        bus(0, 12'h080, 0);
        chk("term 8 word", got, 32'h1);
        be <= 4'h2;
        bus(1, 12'h080, 32'hffffffff);
        bus(0, 12'h080, 0);
        chk("byte lane", got, 32'h0000ff01);
        be <= 4'hf;
        bus(1, 12'h080, 32'h1);
        bus(1, 12'h014, 32'h2);
        bus(1, 12'h000, 32'h4);
        $display("test bus done");
    endtask

    task automatic t_dff;
        mc(0, 32'h060a4000, 32'h100);
        gia_set(0, 1);
        tick(4'h1);
        chk("d out", io_out[0], 1'b1);
        chk("mc feedback", mc_fb[0], 1'b1);
        chk("oe on", io_oe[0], 1'b1);
        gia_set(0, 0);
        chk("no edge", io_out[0], 1'b1);
        gia_set(1, 1);
        tick(4'h1);
        chk("enable low", io_out[0], 1'b1);
        gia_set(1, 0);
        tick(4'h1);
        chk("enable high", io_out[0], 1'b0);
        $display("test dff done");
    endtask

    task automatic t_tff;
        bus(1, 12'h800, 32'h40);
        mc(1, 32'h06080005, 32'h100);
        gia_set(0, 1);
        tick(4'h1);
        chk("other pin", io_out[1], 1'b0);
        tick(4'h2);
        chk("t toggle", io_out[1], 1'b1);
        tick(4'h2);
        chk("t toggle back", io_out[1], 1'b0);
        $display("test tff done");
    endtask

    task automatic t_latch;
        mc(2, 32'h06080002, 32'h100);
        @(posedge mclk);
        u_pins.gclk_q <= 4'h1;
        gia_set(0, 1);
        chk("latch open", io_out[2], 1'b1);
        gia_set(0, 0);
        chk("latch follows", io_out[2], 1'b0);
        u_pins.gclk_q <= 4'h0;
        cyc(6);
        gia_set(0, 1);
        chk("latch closed", io_out[2], 1'b0);
        $display("test latch done");
    endtask

    task automatic t_comb;
        bus(1, 12'h280, 32'h1);
        bus(1, 12'h0a8, 32'h100);
        mc(3, 32'h06080003, 32'h400);
        cyc(6);
        chk("foldback high in", io_out[3], 1'b0);
        gia_set(0, 0);
        chk("foldback low in", io_out[3], 1'b1);
        chk("comb feedback", mc_fb[3], 1'b1);
        u_pins.gts_q <= 1'b1;
        cyc(6);
        chk("global float", io_oe[3], 1'b0);
        u_pins.gts_q <= 1'b0;
        cyc(6);
        chk("float released", io_oe[3], 1'b1);
        $display("test comb done");
    endtask

    task automatic t_input;
        mc(4, 32'h00040000, 32'h0);
        u_pins.ext_en[4]  <= 1'b1;
        u_pins.ext_val[4] <= 1'b1;
        cyc(6);
        chk("pin feedback", pin_fb[4], 1'b1);
        chk("input oe", io_oe[4], 1'b0);
        tick(4'h1);
        chk("direct capture", mc_fb[4], 1'b1);
        u_pins.ext_val[4] <= 1'b0;
        tick(4'h1);
        chk("direct capture low", mc_fb[4], 1'b0);
        $display("test input done");
    endtask

    task automatic t_pull;
        mc(5, 32'h00700000, 32'h0);
        mc(7, 32'h00100000, 32'h0);
        cyc(6);
        chk("pullup", io_pu[5], 1'b1);
        chk("pullup oe", io_oe[5], 1'b0);
        chk("pulled level", pin_fb[5], 1'b1);
        chk("slow slew", io_slow[5], 1'b1);
        chk("oe ctl idle", io_oe[7], 1'b0);
        gia_set(2, 1);
        chk("oe ctl on", io_oe[7], 1'b1);
        gia_set(2, 0);
        $display("test pull done");
    endtask

    task automatic t_preload;
        mc(6, 32'h060a2020, 32'h0);
        mc(8, 32'h06080200, 32'h0);
        bus(1, 12'h800, 32'h100000);
        bus(0, 12'h800, 0);
        chk("preload clears", got, 32'h0);
        cyc(4);
        chk("power up set", io_out[6], 1'b1);
        chk("power up clear", io_out[8], 1'b0);
        gia_set(2, 1);
        chk("async reset", io_out[6], 1'b0);
        chk("async preset", io_out[8], 1'b1);
        $display("test preload done");
    endtask

    // Term 4 as a sum clock; a product would see other edges
    task automatic t_term;
        bus(1, 12'h800, 32'h1);
        bus(1, 12'h040, 32'h3);
        mc(9, 32'h0788000d, 32'h0);
        gia_set(1, 1);
        chk("sum clock first", io_out[9], 1'b1);
        gia_set(0, 1);
        chk("sum clock held", io_out[9], 1'b1);
        clk_en <= 1'b0;
        gia_set(0, 0);
        gia_set(1, 0);
        gia_set(1, 1);
        clk_en <= 1'b1;
        cyc(6);
        chk("frozen edge", io_out[9], 1'b1);
        $display("test term done");
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Whole run needs a few hundred cycles; generous ceiling
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test;
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_bus;
        t_dff;
        t_tff;
        t_latch;
        t_comb;
        t_input;
        t_pull;
        t_preload;
        t_term;
        end_of_test;
    end
endmodule

// ### src/pld_block_pkg.sv
package pld_block_pkg;
    // Block geometry
    localparam int NUM_IN        = 36;
    localparam int NUM_TERMS     = 48;
    localparam int NUM_MC        = 16;
    localparam int NUM_LCT       = 8;
    localparam int NUM_FOLD      = 8;
    localparam int FOLD_BASE     = 40;
    localparam int CLK_TERM_BASE = 4;
    localparam int NUM_CLK_TERMS = 4;
    localparam int NUM_OEC       = 4;
    localparam int NUM_GPIN      = 4;

    // Register map, byte addresses
    localparam logic [1:0]  REGION_TERM = 2'h0;
    localparam logic [1:0]  REGION_MC   = 2'h1;
    localparam logic [11:0] CTRL_ADDR   = 12'h800;
    localparam logic [11:0] STATUS_ADDR = 12'h804;
    localparam logic [31:0] CFG_RESET   = 32'h00000000;

    // Term word 2 fields
    localparam int TRUE_HI_LSB = 0;
    localparam int COMP_HI_LSB = 4;
    localparam int FOLD_LSB    = 8;

    // Macrocell word 0 fields
    localparam int MODE_LSB   = 0;
    localparam int CLK_LSB    = 2;
    localparam int INIT_BIT   = 5;
    localparam int PRE_LSB    = 6;
    localparam int PRE_EN     = 9;
    localparam int RST_LSB    = 10;
    localparam int RST_EN     = 13;
    localparam int CE_LSB     = 14;
    localparam int CE_EN      = 17;
    localparam int DIRECT_BIT = 18;
    localparam int OE_LSB     = 19;
    localparam int SLEW_BIT   = 22;
    localparam int FUNC_LSB   = 23;

    // Control word fields
    localparam int SUM_LSB     = 0;
    localparam int GCLK0_LSB   = 4;
    localparam int GCLK1_LSB   = 6;
    localparam int OEC_LSB     = 8;
    localparam int PRELOAD_BIT = 20;

    // Synchroniser vector layout
    localparam int SYNC_W        = 22;
    localparam int SYNC_GCLK_LSB = 16;
    localparam int SYNC_UCLK_BIT = 20;
    localparam int SYNC_GTS_BIT  = 21;

    typedef enum logic [1:0] {
        STORE_D, STORE_T, STORE_LATCH, STORE_COMB
    } store_type;

    typedef enum logic [2:0] {
        CLK_GLOBAL0, CLK_GLOBAL1, CLK_UNIVERSAL, CLK_TERM4,
        CLK_TERM5, CLK_TERM6, CLK_TERM7, CLK_OWN_TERM
    } clk_src_type;

    typedef enum logic [2:0] {
        OE_OFF, OE_ON, OE_CTL0, OE_CTL1,
        OE_CTL2, OE_CTL3, OE_PULLUP, OE_OWN_TERM
    } oe_mode_type;
endpackage

// ### src/pld_logic_block.sv
// Function
// - 36 interconnect inputs, true and complement, feed 48 product terms.
// - Block holds 16 macrocells fed from the interconnect.
// - Any product term may feed any macrocell, shared freely.
// - Terms 0-7 are control terms for clock, reset, preset, enable.
// - Eight foldback NAND terms feed every term as extra inputs.
// - OR of chosen terms feeds a two-input function mux per macrocell.
// - Storage is D, T, transparent latch or combinational bypass.
// - Each macrocell register picks one of eight clock sources.
// - Two global clocks chosen from four pins, plus a universal clock.
// - Control terms 4-7 used as clocks are product or sum each.
// - Each macrocell comes up cleared or set, chosen per cell.
// - Control terms give asynchronous preset and reset per macrocell.
// - Per-macrocell clock enable; inactive enable holds the register.
// - Output pin buffer enabled; macrocell result feeds back inward.
// - Input pin buffer off; pin value feeds back; buried cell usable.
// - Input-configured macrocell has a direct pin-to-register path.
// - Output enable selector has eight modes, one a weak pull-up.
// - Block offers four output enable controls for its I/O cells.
// - One configuration bit per I/O cell selects reduced slew.
// - Global control floats all outputs at once for board test.
`timescale 1ns/1ps
module pld_logic_block
    import pld_block_pkg::*;
(
    // Clock, reset, freeze
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    // Avalon-MM slave
    input  wire logic [11:0]         avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    // Interconnect side
    input  wire logic [NUM_IN-1:0]   global_interconnect_array_in,
    output logic      [NUM_MC-1:0]   mc_feedback,
    output logic      [NUM_MC-1:0]   pin_feedback,
    // Pins
    input  wire logic [NUM_GPIN-1:0] gclk_pin,
    input  wire logic                uclk_pin,
    input  wire logic                global_tristate_pin,
    input  wire logic [NUM_MC-1:0]   io_in,
    output logic      [NUM_MC-1:0]   io_out,
    output logic      [NUM_MC-1:0]   io_oe,
    output logic      [NUM_MC-1:0]   io_pullup,
    output logic      [NUM_MC-1:0]   io_slow
);

    function automatic logic term_eval(
        input logic [31:0]         w0,
        input logic [31:0]         w1,
        input logic [31:0]         w2,
        input logic [NUM_IN-1:0]   x,
        input logic [NUM_FOLD-1:0] fb,
        input logic                sum
    );
        logic [NUM_IN-1:0]   tm;
        logic [NUM_IN-1:0]   cm;
        logic [NUM_FOLD-1:0] fm;
        tm = {w2[TRUE_HI_LSB +: 4], w0};
        cm = {w2[COMP_HI_LSB +: 4], w1};
        fm = w2[FOLD_LSB +: NUM_FOLD];
        // Unused literals drop out: 1 for a product, 0 for a sum
        if (sum)
            term_eval = |(tm & x) | |(cm & ~x) | |(fm & fb);
        else
            term_eval = &(~tm | x) & &(~cm | ~x) & &(~fm | fb);
    endfunction

    function automatic logic [31:0] be_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        be_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b])
                be_merge[8*b +: 8] = wd[8*b +: 8];
        end
    endfunction

    logic [31:0]         term_cfg_q [NUM_TERMS][3];
    logic [31:0]         mc_cfg_q   [NUM_MC][4];
    logic [31:0]         ctrl_q;
    logic                preload_q;
    logic [SYNC_W-1:0]   pin_s1_q;
    logic [SYNC_W-1:0]   pin_s2_q;
    logic [NUM_MC-1:0]   mc_q;
    logic [NUM_MC-1:0]   clk_prev_q;

    logic [NUM_MC-1:0]    io_sync;
    logic [NUM_GPIN-1:0]  gclk_sync;
    logic                 gclk0;
    logic                 gclk1;
    logic [NUM_FOLD-1:0]  fold_nand;
    logic [NUM_TERMS-1:0] product_term;
    logic [NUM_LCT-1:0]   local_control_terms;
    logic [NUM_OEC-1:0]   oe_ctl;
    logic [NUM_MC-1:0]    d_v;
    logic [NUM_MC-1:0]    src_v;
    logic [NUM_MC-1:0]    edge_v;
    logic [NUM_MC-1:0]    hold_v;
    logic [NUM_MC-1:0]    pre_v;
    logic [NUM_MC-1:0]    clr_v;
    logic [NUM_MC-1:0]    result_v;
    logic [NUM_MC-1:0]    oe_v;
    logic [NUM_MC-1:0]    pu_v;
    logic [NUM_MC-1:0]    slew_v;
    logic [NUM_MC-1:0]    init_v;

    // Pins cross into mclk through two flops
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else if (clk_en) begin
            pin_s1_q <= {global_tristate_pin, uclk_pin, gclk_pin, io_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign io_sync   = pin_s2_q[NUM_MC-1:0];
    assign gclk_sync = pin_s2_q[SYNC_GCLK_LSB +: NUM_GPIN];
    assign gclk0     = gclk_sync[ctrl_q[GCLK0_LSB +: 2]];
    assign gclk1     = gclk_sync[ctrl_q[GCLK1_LSB +: 2]];

    // Foldback terms see no foldback inputs, which breaks the loop
    always_comb begin
        for (int f = 0; f < NUM_FOLD; f++) begin
            fold_nand[f] = ~term_eval(term_cfg_q[FOLD_BASE+f][0],
                                      term_cfg_q[FOLD_BASE+f][1],
                                      term_cfg_q[FOLD_BASE+f][2],
                                      global_interconnect_array_in,
                                      '0, 1'b0);
        end
        for (int t = 0; t < NUM_TERMS; t++) begin
            product_term[t] = term_eval(term_cfg_q[t][0],
                                        term_cfg_q[t][1],
                                        term_cfg_q[t][2],
                                        global_interconnect_array_in,
                                        fold_nand, 1'b0);
        end
        for (int k = 0; k < NUM_CLK_TERMS; k++) begin
            product_term[CLK_TERM_BASE+k] = term_eval(
                term_cfg_q[CLK_TERM_BASE+k][0],
                term_cfg_q[CLK_TERM_BASE+k][1],
                term_cfg_q[CLK_TERM_BASE+k][2],
                global_interconnect_array_in,
                fold_nand, ctrl_q[SUM_LSB+k]);
        end
        local_control_terms = product_term[NUM_LCT-1:0];
        for (int i = 0; i < NUM_OEC; i++) begin
            oe_ctl[i] = local_control_terms[ctrl_q[OEC_LSB+3*i +: 3]];
        end
    end

    always_comb begin
        logic [31:0]          w;
        logic [NUM_TERMS-1:0] mask;
        logic [5:0]           bsel;
        logic                 bterm;
        logic                 or_sum;
        logic                 func;
        w      = '0;
        mask   = '0;
        bsel   = '0;
        bterm  = 1'b0;
        or_sum = 1'b0;
        func   = 1'b0;
        for (int m = 0; m < NUM_MC; m++) begin
            w      = mc_cfg_q[m][0];
            mask   = {mc_cfg_q[m][2][15:0], mc_cfg_q[m][1]};
            bsel   = mc_cfg_q[m][3][5:0];
            bterm  = (bsel < NUM_TERMS) ? product_term[bsel] : 1'b0;
            or_sum = |(mask & product_term);
            func   = w[FUNC_LSB + int'({or_sum, bterm})];
            d_v[m] = w[DIRECT_BIT] ? io_sync[m] : func;
            unique case (clk_src_type'(w[CLK_LSB +: 3]))
                CLK_GLOBAL0:   src_v[m] = gclk0;
                CLK_GLOBAL1:   src_v[m] = gclk1;
                CLK_UNIVERSAL: src_v[m] = pin_s2_q[SYNC_UCLK_BIT];
                CLK_TERM4:     src_v[m] = local_control_terms[4];
                CLK_TERM5:     src_v[m] = local_control_terms[5];
                CLK_TERM6:     src_v[m] = local_control_terms[6];
                CLK_TERM7:     src_v[m] = local_control_terms[7];
                CLK_OWN_TERM:  src_v[m] = bterm;
            endcase
            edge_v[m] = src_v[m] & ~clk_prev_q[m];
            hold_v[m] = w[CE_EN] & ~local_control_terms[w[CE_LSB +: 3]];
            clr_v[m]  = w[RST_EN] & local_control_terms[w[RST_LSB +: 3]];
            pre_v[m]  = w[PRE_EN] & local_control_terms[w[PRE_LSB +: 3]];
            init_v[m] = w[INIT_BIT];
            slew_v[m] = w[SLEW_BIT];
            result_v[m] = (store_type'(w[MODE_LSB +: 2]) == STORE_COMB)
                        ? d_v[m] : mc_q[m];
            pu_v[m] = 1'b0;
            unique case (oe_mode_type'(w[OE_LSB +: 3]))
                OE_OFF:      oe_v[m] = 1'b0;
                OE_ON:       oe_v[m] = 1'b1;
                OE_CTL0:     oe_v[m] = oe_ctl[0];
                OE_CTL1:     oe_v[m] = oe_ctl[1];
                OE_CTL2:     oe_v[m] = oe_ctl[2];
                OE_CTL3:     oe_v[m] = oe_ctl[3];
                OE_PULLUP: begin
                    oe_v[m] = 1'b0;
                    pu_v[m] = 1'b1;
                end
                OE_OWN_TERM: oe_v[m] = bterm;
            endcase
        end
    end

    // Asynchronous controls are modelled as sampled, reset over preset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mc_q       <= '0;
            clk_prev_q <= '0;
        end else if (clk_en) begin
            clk_prev_q <= src_v;
            for (int m = 0; m < NUM_MC; m++) begin
                if (preload_q)
                    mc_q[m] <= init_v[m];
                else if (clr_v[m])
                    mc_q[m] <= 1'b0;
                else if (pre_v[m])
                    mc_q[m] <= 1'b1;
                else if (!hold_v[m]) begin
                    unique case (store_type'(mc_cfg_q[m][0][MODE_LSB +: 2]))
                        STORE_D:     if (edge_v[m]) mc_q[m] <= d_v[m];
                        STORE_T:     if (edge_v[m])
                            mc_q[m] <= mc_q[m] ^ d_v[m];
                        STORE_LATCH: if (src_v[m]) mc_q[m] <= d_v[m];
                        STORE_COMB:  mc_q[m] <= mc_q[m];
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            io_out       <= '0;
            io_oe        <= '0;
            io_pullup    <= '0;
            io_slow      <= '0;
            mc_feedback  <= '0;
            pin_feedback <= '0;
        end else if (clk_en) begin
            io_out       <= result_v;
            io_oe        <= pin_s2_q[SYNC_GTS_BIT] ? '0 : oe_v;
            io_pullup    <= pu_v;
            io_slow      <= slew_v;
            mc_feedback  <= result_v;
            pin_feedback <= io_sync;
        end
    end

    // Register bus
    logic [1:0]  region;
    logic [5:0]  t_idx;
    logic [3:0]  m_idx;
    logic [1:0]  k_idx;
    logic        term_hit;
    logic        mc_hit;
    logic        wr_fire;
    logic [31:0] rd_mux;

    assign region   = avs_address[11:10];
    assign t_idx    = avs_address[9:4];
    assign m_idx    = avs_address[7:4];
    assign k_idx    = avs_address[3:2];
    assign term_hit = (region == REGION_TERM) && (t_idx < NUM_TERMS)
                   && (k_idx != 2'h3);
    assign mc_hit   = (region == REGION_MC) && (avs_address[9:8] == 2'h0);
    assign wr_fire  = clk_en && avs_write && !avs_waitrequest;

    always_comb begin
        rd_mux = '0;
        if (term_hit)
            rd_mux = term_cfg_q[t_idx][k_idx];
        else if (mc_hit)
            rd_mux = mc_cfg_q[m_idx][k_idx];
        else if ({avs_address[11:2], 2'h0} == CTRL_ADDR)
            rd_mux = ctrl_q;
        else if ({avs_address[11:2], 2'h0} == STATUS_ADDR)
            rd_mux = {io_sync, result_v};
    end

    // One wait state: answer flops settle before the master samples
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else if (clk_en) begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? rd_mux : '0;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int t = 0; t < NUM_TERMS; t++) begin
                for (int k = 0; k < 3; k++) term_cfg_q[t][k] <= CFG_RESET;
            end
            for (int m = 0; m < NUM_MC; m++) begin
                for (int k = 0; k < 4; k++) mc_cfg_q[m][k] <= CFG_RESET;
            end
            ctrl_q <= CFG_RESET;
        end else if (wr_fire) begin
            if (term_hit)
                term_cfg_q[t_idx][k_idx] <= be_merge(
                    term_cfg_q[t_idx][k_idx], avs_writedata, avs_byteenable);
            else if (mc_hit)
                mc_cfg_q[m_idx][k_idx] <= be_merge(
                    mc_cfg_q[m_idx][k_idx], avs_writedata, avs_byteenable);
            else if ({avs_address[11:2], 2'h0} == CTRL_ADDR) begin
                ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
                ctrl_q[PRELOAD_BIT] <= 1'b0;
            end
        end
    end

    // Self-clearing power-up load strobe
    always_ff @(posedge mclk) begin
        if (!rst_n)
            preload_q <= 1'b0;
        else if (clk_en)
            preload_q <= wr_fire && avs_byteenable[PRELOAD_BIT/8]
                      && ({avs_address[11:2], 2'h0} == CTRL_ADDR)
                      && avs_writedata[PRELOAD_BIT];
    end

    // Checks on macrocell 0 stand for all cells
    store_type   mode0;
    oe_mode_type oe0;
    assign mode0 = store_type'(mc_cfg_q[0][0][MODE_LSB +: 2]);
    assign oe0   = oe_mode_type'(mc_cfg_q[0][0][OE_LSB +: 3]);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_free0;
        clk_en && !preload_q && !clr_v[0] && !pre_v[0] && !hold_v[0];
    endsequence

    sequence s_d_edge0;
        s_free0 ##0 (edge_v[0] && mode0 == STORE_D);
    endsequence

    a_d_capture: assert property (s_d_edge0
        |=> mc_q[0] == $past(d_v[0]))
        else $error("D register missed its clock edge");
    a_t_toggle: assert property ((s_free0 ##0 (edge_v[0]
        && mode0 == STORE_T)) |=> mc_q[0] != $past(mc_q[0]) == $past(d_v[0]))
        else $error("T register toggled wrongly");
    a_reset_term: assert property (clk_en && !preload_q && clr_v[0]
        |=> !mc_q[0])
        else $error("Reset term did not clear the register");
    a_preset_term: assert property (clk_en && !preload_q && !clr_v[0]
        && pre_v[0] |=> mc_q[0])
        else $error("Preset term did not set the register");
    a_ce_hold: assert property (clk_en && !preload_q && !clr_v[0]
        && !pre_v[0] && hold_v[0] |=> $stable(mc_q[0]))
        else $error("Register changed while its enable was off");
    a_init_load: assert property (clk_en && preload_q
        |=> mc_q == $past(init_v))
        else $error("Power-up value not loaded");
    a_gts_off: assert property (clk_en && pin_s2_q[SYNC_GTS_BIT]
        |=> io_oe == '0)
        else $error("Output driven during global three-state");
    a_pullup_hiz: assert property (clk_en && oe0 == OE_PULLUP
        |=> io_pullup[0] && !io_oe[0])
        else $error("Pull-up mode drove the pin");
    a_slew_bit: assert property (clk_en |=> io_slow == $past(slew_v))
        else $error("Slew output does not follow its bit");
    // Three live edges, so no value from reset or a freeze is compared
    a_pin_return: assert property (clk_en ##1 clk_en ##1 clk_en
        |=> pin_feedback == $past(io_in, 3))
        else $error("Pin feedback lost the pin value");
    a_mc_return: assert property (clk_en
        |=> mc_feedback == $past(result_v))
        else $error("Macrocell feedback mismatch");
endmodule
